// ---- logic/srsr_core.sv ----
// Refresh scheduling, self refresh and partial-array masking of the memory device
`timescale 1ns/1ps
module srsr_core
	import srsr_pkg::*;
#(
	parameter bit SEG_MASK_SUPPORTED = 1'b1
)
(
	// Core clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Memory command pins
	input wire logic mem_ck,
	input wire logic clock_enable_pin,
	input wire logic chip_select_n,
	input wire logic [CA_W-1:0] cmd_addr,
	// Status
	output logic in_self_refresh,
	output logic int_clk_en,
	output logic sr_exit_busy,
	output logic [NUM_BANKS-1:0] bank_busy,
	output logic [2:0] pb_target,
	// Internal refresh events
	output srsr_ref_t array_refresh,
	// Mask registers as seen by the array
	output logic [7:0] bank_refresh_mask,
	output logic [7:0] segment_refresh_mask
);
	logic rst_meta_q;
	logic rst_n;
	srsr_pins_t pins_raw;
	srsr_pins_t pins;
	logic ck_rise;
	logic ck_fall;

	srsr_state_t state_q;
	srsr_state_t state_d;
	logic cke_prev_q;
	logic [CNT_W-1:0] exit_cnt_q;
	logic [CNT_W-1:0] sweep_tmr_q;
	logic [CNT_W-1:0] busy_cnt_q;
	logic sweep_on_q;
	logic [5:0] sweep_idx_q;
	logic mrw_pend_q;
	logic [5:0] mrw_ma_hi_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	assign pins_raw = '{ck: mem_ck, cke: clock_enable_pin, cs_n: chip_select_n,
		ca: cmd_addr};

	srsr_pin_sync u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pins_in(pins_raw),
		.pins_out(pins),
		.ck_rise(ck_rise),
		.ck_fall(ck_fall)
	);

	// Location refreshes only when both mask bits are clear
	function automatic logic loc_enabled(input logic [2:0] bank, input logic [2:0] seg,
		input logic [7:0] bmask, input logic [7:0] smask, input logic seg_ok);
		loc_enabled = !bmask[bank] && !(seg_ok && smask[seg]);
	endfunction

	// Command decode at a rising link clock edge
	wire sel = !pins.cs_n;
	wire ref_pattern = sel && !pins.ca[CA_B0] && !pins.ca[CA_B1] && pins.ca[CA_B2];
	wire sr_entry = ck_rise && cke_prev_q && !pins.cke && ref_pattern && (state_q == ST_ACTIVE);
	wire cmd_ok = ck_rise && cke_prev_q && pins.cke;
	wire ref_ab = cmd_ok && ref_pattern && pins.ca[CA_B3];
	wire ref_pb = cmd_ok && ref_pattern && !pins.ca[CA_B3];
	wire mrw_cmd = cmd_ok && sel && (pins.ca[CA_B3:CA_B0] == 4'h0);
	wire [7:0] mrw_addr = {mrw_ma_hi_q, pins.ca[1:0]};
	wire [7:0] mrw_data = pins.ca[9:2];
	wire mrw_fire = ck_fall && mrw_pend_q;
	wire in_active = (state_q == ST_ACTIVE);
	// only clock enable is observed in self refresh
	wire sr_exit = ck_rise && pins.cke && (state_q == ST_SREF);
	wire exit_done = (state_q == ST_EXIT) && (exit_cnt_q == '0);
	wire sweep_due = (state_q == ST_SREF) && (sweep_tmr_q == '0);
	wire sweep_last = (sweep_idx_q == 6'h3f);
	wire sweep_hit = loc_enabled(sweep_idx_q[5:3], sweep_idx_q[2:0], bank_refresh_mask,
		segment_refresh_mask, SEG_MASK_SUPPORTED);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_ACTIVE: begin
				if (sr_entry) begin
					state_d = ST_SREF;
				end
			end
			ST_SREF: begin
				if (sr_exit) begin
					state_d = ST_EXIT;
				end
			end
			ST_EXIT: begin
				if (exit_done) begin
					state_d = ST_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_ACTIVE;
			cke_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (ck_rise) begin
				cke_prev_q <= pins.cke;
			end
		end
	end

	// exit time starts at the edge that registers the exit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exit_cnt_q <= '0;
		end else if (sr_exit) begin
			exit_cnt_q <= CNT_W'(SR_EXIT_CYC - 1);
		end else if (exit_cnt_q != '0) begin
			exit_cnt_q <= exit_cnt_q - 1'b1;
		end
	end

	// a full sweep starts at entry and runs 64 cycles, longer than the minimum residency
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sweep_tmr_q <= '0;
		end else if (sr_entry || sweep_due) begin
			sweep_tmr_q <= CNT_W'(SWEEP_CYC - 1);
		end else if (state_q == ST_SREF) begin
			sweep_tmr_q <= sweep_tmr_q - 1'b1;
		end
	end

	// internal timer drives sweeps over every bank and segment
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sweep_on_q <= 1'b0;
			sweep_idx_q <= '0;
		end else if (sr_entry || (sweep_due && !sweep_on_q)) begin
			sweep_on_q <= 1'b1;
			sweep_idx_q <= '0;
		end else if (sweep_on_q) begin
			sweep_idx_q <= sweep_idx_q + 1'b1;
			sweep_on_q <= !sweep_last;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			array_refresh <= '0;
		end else begin
			array_refresh.strobe <= sweep_on_q && sweep_hit;
			array_refresh.bank <= sweep_idx_q[5:3];
			array_refresh.seg <= sweep_idx_q[2:0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pb_target <= '0;
		end else if (sr_exit || (ref_ab && in_active)) begin
			pb_target <= '0;
		end else if (ref_pb && in_active) begin
			pb_target <= pb_target + 1'b1;
		end
	end

	// only the refreshed bank shows busy after a per-bank refresh, every bank after an all-bank refresh
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bank_busy <= '0;
			busy_cnt_q <= '0;
		end else if (ref_ab && in_active) begin
			bank_busy <= '1;
			busy_cnt_q <= CNT_W'(AB_CYC - 1);
		end else if (ref_pb && in_active) begin
			bank_busy <= NUM_BANKS'(1) << pb_target;
			busy_cnt_q <= CNT_W'(PB_CYC - 1);
		end else if (busy_cnt_q != '0) begin
			busy_cnt_q <= busy_cnt_q - 1'b1;
		end else begin
			bank_busy <= '0;
		end
	end

	// mode register write, address split over both clock edges
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mrw_pend_q <= 1'b0;
			mrw_ma_hi_q <= '0;
			bank_refresh_mask <= BANK_MASK_RST;
			segment_refresh_mask <= SEG_MASK_RST;
		end else begin
			if (mrw_cmd && in_active) begin
				mrw_pend_q <= 1'b1;
				mrw_ma_hi_q <= pins.ca[CA_W-1:CA_MA_LO];
			end else if (mrw_fire) begin
				mrw_pend_q <= 1'b0;
			end
			if (mrw_fire && mrw_addr == MR_BANK_MASK_ADDR) begin
				bank_refresh_mask <= mrw_data;
			end
			// segment mask only exists on larger densities
			if (mrw_fire && mrw_addr == MR_SEG_MASK_ADDR && SEG_MASK_SUPPORTED) begin
				segment_refresh_mask <= mrw_data;
			end
		end
	end

	// internal clock gated off while in self refresh
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_self_refresh <= 1'b0;
			int_clk_en <= 1'b0;
			sr_exit_busy <= 1'b0;
		end else begin
			in_self_refresh <= (state_d == ST_SREF);
			int_clk_en <= (state_d != ST_SREF);
			sr_exit_busy <= (state_d == ST_EXIT);
		end
	end
endmodule

// ---- inc/srsr_pkg.sv ----
// Constants, types and encodings for the refresh and self-refresh block
package srsr_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS = 10;

	// Timing figures in ns, plain defaults
	localparam int SR_MIN_TIME_NS = 15;
	localparam int SR_EXIT_TIME_NS = 140;
	localparam int PB_CYCLE_TIME_NS = 60;
	localparam int AB_CYCLE_TIME_NS = 130;
	localparam int SR_SWEEP_INTERVAL_NS = 7800;

	// Least times round up, the sweep interval is a longest time and rounds down
	localparam int SR_MIN_CYC = (SR_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SR_EXIT_CYC = (SR_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PB_CYC = (PB_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AB_CYC = (AB_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SWEEP_CYC = SR_SWEEP_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 12;

	// Geometry
	localparam int NUM_BANKS = 8;
	localparam int NUM_SEGS = 8;
	localparam int CA_W = 10;

	// Mode register addresses and reset values
	localparam logic [7:0] MR_BANK_MASK_ADDR = 8'h10;
	localparam logic [7:0] MR_SEG_MASK_ADDR = 8'h11;
	localparam logic [7:0] BANK_MASK_RST = 8'h00;
	localparam logic [7:0] SEG_MASK_RST = 8'h00;

	// Command/address bit positions
	localparam int CA_B0 = 0;
	localparam int CA_B1 = 1;
	localparam int CA_B2 = 2;
	localparam int CA_B3 = 3;
	localparam int CA_MA_LO = 4;

	// Sampled command pins
	typedef struct packed {
		logic ck;
		logic cke;
		logic cs_n;
		logic [CA_W-1:0] ca;
	} srsr_pins_t;

	localparam int PINS_W = $bits(srsr_pins_t);

	// Internal refresh event
	typedef struct packed {
		logic strobe;
		logic [2:0] bank;
		logic [2:0] seg;
	} srsr_ref_t;

	typedef enum logic [2:0] {
		ST_ACTIVE = 3'b001,
		ST_SREF = 3'b010,
		ST_EXIT = 3'b100
	} srsr_state_t;

endpackage

// ---- logic/srsr_pin_sync.sv ----
// Two-stage synchroniser for the command pins with clock edge detection
`timescale 1ns/1ps
module srsr_pin_sync
	import srsr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Raw pins
	input wire srsr_pins_t pins_in,
	// Synchronised pins and link clock edges
	output srsr_pins_t pins_out,
	output logic ck_rise,
	output logic ck_fall
);
	srsr_pins_t meta_q;
	srsr_pins_t sync_q;
	srsr_pins_t hold_q;
	logic rise_d;
	logic fall_d;

	// Edges come from the second and third stages only
	assign rise_d = sync_q.ck && !hold_q.ck;
	assign fall_d = !sync_q.ck && hold_q.ck;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
			hold_q <= '0;
			ck_rise <= 1'b0;
			ck_fall <= 1'b0;
		end else begin
			meta_q <= pins_in;
			sync_q <= meta_q;
			hold_q <= sync_q;
			ck_rise <= rise_d;
			ck_fall <= fall_d;
		end
	end

	// Data lag the second stage by one stage, in step with the registered edge pulses, so pins hold the value at the edge
	assign pins_out = hold_q;
endmodule

// ---- dv/srsr_core_checker.sv ----
// Assertions on the ports of the refresh and self-refresh block
`timescale 1ns/1ps
module srsr_core_checker
	import srsr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Status and refresh outputs
	input wire logic in_self_refresh,
	input wire logic int_clk_en,
	input wire logic sr_exit_busy,
	input wire logic [NUM_BANKS-1:0] bank_busy,
	input wire logic [2:0] pb_target,
	input wire srsr_ref_t array_refresh,
	input wire logic [7:0] bank_refresh_mask,
	input wire logic [7:0] segment_refresh_mask
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	wire logic hit_masked;
	assign hit_masked = bank_refresh_mask[array_refresh.bank] |
		segment_refresh_mask[array_refresh.seg];
	chk_clk_gated: assert property (in_self_refresh |-> !int_clk_en)
		else $error("internal clock runs in self refresh");
	chk_first_ref: assert property ($rose(in_self_refresh) |-> ##[1:2] array_refresh.strobe)
		else $error("no early refresh after entry");
	chk_mask_obey: assert property (array_refresh.strobe |-> !hit_masked)
		else $error("masked location refreshed");
	chk_pb_step: assert property ($changed(pb_target) && |pb_target |->
		pb_target == $past(pb_target) + 3'h1) else $error("per-bank target skipped");
	chk_pb_busy: assert property ($changed(pb_target) && |pb_target |->
		bank_busy == 8'h1 << $past(pb_target)) else $error("wrong bank busy");
	chk_exit_len: assert property ($rose(sr_exit_busy) |-> ##13 sr_exit_busy ##1 !sr_exit_busy)
		else $error("exit interval length wrong");
	chk_exit_sync: assert property ($fell(in_self_refresh) |->
		sr_exit_busy && int_clk_en && pb_target == 3'h0) else $error("bad exit state");
	chk_sr_deaf: assert property (in_self_refresh && $past(in_self_refresh) |->
		$stable(pb_target) && $stable(bank_refresh_mask)) else $error("input heard in self refresh");
	chk_busy_shape: assert property (bank_busy != 8'hff |-> $onehot0(bank_busy))
		else $error("more than one bank busy");
	chk_exit_awake: assert property (sr_exit_busy |-> int_clk_en && !in_self_refresh)
		else $error("clock gated during exit");
endmodule

bind srsr_core srsr_core_checker u_chk (
	.clock(clock),
	.resetn(resetn),
	.in_self_refresh(in_self_refresh),
	.int_clk_en(int_clk_en),
	.sr_exit_busy(sr_exit_busy),
	.bank_busy(bank_busy),
	.pb_target(pb_target),
	.array_refresh(array_refresh),
	.bank_refresh_mask(bank_refresh_mask),
	.segment_refresh_mask(segment_refresh_mask)
);

// ---- dv/srsr_ctl_model.sv ----
// Memory controller model driving the command pins
`timescale 1ns/1ps
module srsr_ctl_model
	import srsr_pkg::*;
(
	// Core clock
	clock,
	// Command pins
	mem_ck,
	cke,
	cs_n,
	ca
);
	input wire logic clock;
	output logic mem_ck = 1'b0;
	output logic cke = 1'b1;
	output logic cs_n = 1'b1;
	output logic [CA_W-1:0] ca = 10'h0;
	// link clock runs only inside a command cycle, 160 ns back to back
	task automatic cyc(input logic k, input logic s, input logic [CA_W-1:0] cr,
		input logic [CA_W-1:0] cf);
		@(posedge clock);
		cke <= k;
		cs_n <= s;
		ca <= cr;
		repeat (4) @(posedge clock);
		mem_ck <= 1'b1;
		repeat (4) @(posedge clock);
		ca <= cf;
		repeat (4) @(posedge clock);
		mem_ck <= 1'b0;
		repeat (2) @(posedge clock);
		// Deselected lines must not look like held data
		cs_n <= 1'b1;
		ca <= ~cf;
		@(posedge clock);
		@(negedge clock);
	endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the refresh and self-refresh block
`timescale 1ns/1ps
module tb_top
	import srsr_pkg::*;
;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic mem_ck, cke, cs_n, in_sr, clk_en, xbusy;
	logic [CA_W-1:0] ca;
	logic [7:0] busy, bm, sm, bmr, smr;
	logic [2:0] pbt;
	srsr_ref_t ar;
	logic [5:0] expq[$];
	int failures = 0;
	int checks = 0;
	integer seed = 32'hfee5;

	initial forever #5 clock = ~clock;

	srsr_core DUT (.clock(clock), .resetn(resetn), .mem_ck(mem_ck), .clock_enable_pin(cke),
		.chip_select_n(cs_n), .cmd_addr(ca), .in_self_refresh(in_sr), .int_clk_en(clk_en),
		.sr_exit_busy(xbusy), .bank_busy(busy), .pb_target(pbt), .array_refresh(ar),
		.bank_refresh_mask(bmr), .segment_refresh_mask(smr));
	srsr_ctl_model u_ctl (.clock(clock), .mem_ck(mem_ck), .cke(cke), .cs_n(cs_n), .ca(ca));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic mode_reg_write(input logic [7:0] a, input logic [7:0] d);
		u_ctl.cyc(1'b1, 1'b0, {a[7:2], 4'h0}, {d, a[1:0]});
	endtask

	task automatic test_done();
		$display("failures %0d checks %0d", failures, checks);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	always @(negedge clock) begin
		if (ar.strobe === 1'b1) begin
			if (expq.size() == 0) begin
				failures++;
				$display("CHECK FAILED %0t unexpected refresh", $time);
			end else begin
				chk({2'h0, ar.bank, ar.seg}, {2'h0, expq.pop_front()});
			end
		end
	end

	initial begin
		int n;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		chk(bmr, 8'h00);
		chk(smr, 8'h00);
		u_ctl.cyc(1'b1, 1'b1, 10'h3ff, 10'h3ff);
		for (int i = 1; i <= 9; i++) begin
			u_ctl.cyc(1'b1, 1'b0, 10'h004, 10'($random(seed)));
			chk({5'h0, pbt}, 8'(i % 8));
			chk(busy, 8'h00);
		end
		bm = 8'($random(seed));
		sm = 8'($random(seed));
		bm[0] = 1'b0;
		sm[0] = 1'b0;
		mode_reg_write(MR_BANK_MASK_ADDR, bm);
		mode_reg_write(MR_SEG_MASK_ADDR, sm);
		mode_reg_write(8'h12, ~bm);
		chk(bmr, bm);
		chk(smr, sm);
		for (int b = 0; b < 8; b++)
			for (int s = 0; s < 8; s++)
				if (!bm[b] && !sm[s]) expq.push_back(6'(b * 8 + s));
		u_ctl.cyc(1'b0, 1'b0, 10'h004, 10'h2aa);
		u_ctl.cyc(1'b0, 1'b1, 10'h3ff, 10'h3ff);
		u_ctl.cyc(1'b0, 1'b0, 10'h004, 10'h155);
		chk({7'h0, in_sr}, 8'h01);
		chk({7'h0, clk_en}, 8'h00);
		chk({5'h0, pbt}, 8'h01);
		n = 0;
		while (expq.size() != 0 && n < 300) begin
			@(posedge clock);
			n++;
		end
		if (expq.size() != 0) begin
			failures++;
			$display("CHECK FAILED %0t sweep timeout", $time);
		end else begin
			u_ctl.cyc(1'b0, 1'b1, 10'h3ff, 10'h3ff);
			u_ctl.cyc(1'b0, 1'b1, 10'h3ff, 10'h3ff);
			u_ctl.cyc(1'b1, 1'b1, 10'h3ff, 10'h3ff);
			chk({5'h0, xbusy, in_sr, clk_en}, 8'h05);
			chk({5'h0, pbt}, 8'h00);
			u_ctl.cyc(1'b1, 1'b1, 10'h3ff, 10'h3ff);
			u_ctl.cyc(1'b1, 1'b0, 10'h004, 10'h155);
			chk({5'h0, pbt}, 8'h01);
			u_ctl.cyc(1'b1, 1'b0, 10'h00c, 10'h2aa);
			chk({5'h0, pbt}, 8'h00);
			chk(busy, 8'hff);
			chk(8'(expq.size()), 8'h00);
		end
		test_done();
	end
endmodule
